// ---- verilog/efrl_top.sv ----
// efrl_top: event, fault and maintenance record logger with time tags.
// assumes prot_tick_in pulses once per protection run and all inputs are clk_in synchronous.
`timescale 1ns/1ps
module efrl_top #(
  parameter int MS_CYCLES = efrl_pkg::EFRL_MS_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic store_rst_in,
  input wire logic prot_tick_in,
  input wire logic [efrl_pkg::EFRL_IO_W-1:0] opto_in,
  input wire logic [efrl_pkg::EFRL_IO_W-1:0] relay_in,
  input wire logic [efrl_pkg::EFRL_IO_W-1:0] alarm_in,
  input wire logic fault_trig_in,
  input wire logic [efrl_pkg::EFRL_VAL_W-1:0] fault_data_in,
  input wire logic maint_trig_in,
  input wire logic [efrl_pkg::EFRL_VAL_W-1:0] maint_data_in,
  input wire logic [efrl_pkg::EFRL_LED_W-1:0] trip_in,
  input wire logic [efrl_pkg::EFRL_LED_W-1:0] elem_active_in,
  output logic [efrl_pkg::EFRL_LED_W-1:0] trip_led_out,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out
);
  import efrl_pkg::*;

  localparam logic [EFRL_MS_CNT_W-1:0] MS_LAST = EFRL_MS_CNT_W'(MS_CYCLES - 1);

  efrl_store_if #(.IW(EFRL_EVT_IW), .DW(EFRL_EVT_DW)) evt ();
  efrl_store_if #(.IW(EFRL_REC_IW), .DW(EFRL_REC_DW)) flt ();
  efrl_store_if #(.IW(EFRL_REC_IW), .DW(EFRL_REC_DW)) mnt ();

  efrl_ring #(.DEPTH(EFRL_EVT_DEPTH), .IW(EFRL_EVT_IW), .DW(EFRL_EVT_DW)) u_evt (
    .clk_in(clk_in),
    .store_rst_in(store_rst_in),
    .st(evt.store)
  );
  efrl_ring #(.DEPTH(EFRL_REC_DEPTH), .IW(EFRL_REC_IW), .DW(EFRL_REC_DW)) u_flt (
    .clk_in(clk_in),
    .store_rst_in(store_rst_in),
    .st(flt.store)
  );
  efrl_ring #(.DEPTH(EFRL_REC_DEPTH), .IW(EFRL_REC_IW), .DW(EFRL_REC_DW)) u_mnt (
    .clk_in(clk_in),
    .store_rst_in(store_rst_in),
    .st(mnt.store)
  );

  function automatic logic [31:0] width_mask(input logic [1:0] code);
    unique case (code)
      2'h0: width_mask = EFRL_MASK12;
      2'h1: width_mask = EFRL_MASK16;
      2'h2: width_mask = EFRL_MASK24;
      2'h3: width_mask = EFRL_MASK32;
    endcase
  endfunction : width_mask

  function automatic logic [4:0] lowest_bit(input logic [31:0] v);
    lowest_bit = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        lowest_bit = 5'(i);
      end
    end
  endfunction : lowest_bit

  // text follows the event kind; alarms pick on or off from the stored state
  function automatic logic [127:0] ev_text(input efrl_ev_t t, input logic on);
    unique case (t)
      EFRL_EV_OPTO: ev_text = EFRL_TXT_OPTO;
      EFRL_EV_RELAY: ev_text = EFRL_TXT_RELAY;
      EFRL_EV_ALARM: ev_text = on ? EFRL_TXT_ALM_ON : EFRL_TXT_ALM_OFF;
      EFRL_EV_FAULT: ev_text = EFRL_TXT_FAULT;
      EFRL_EV_MAINT: ev_text = EFRL_TXT_MAINT;
      default: ev_text = '0;
    endcase
  endfunction : ev_text

  logic [3:0] ctrl_reg;
  logic [EFRL_EVT_IW-1:0] evt_sel_reg;
  logic [EFRL_REC_IW-1:0] flt_sel_reg;
  logic [EFRL_REC_IW-1:0] mnt_sel_reg;
  logic [EFRL_RTC_HI_W-1:0] rtc_stage_reg;
  logic [EFRL_TIME_W-1:0] rtc_reg;
  logic [EFRL_MS_CNT_W-1:0] ms_cnt_reg;
  logic [EFRL_LED_W-1:0] led_reg;
  logic [EFRL_LED_W-1:0] led_next;
  logic primed_reg;
  logic [31:0] opto_snap_reg;
  logic [31:0] relay_snap_reg;
  logic [31:0] alarm_snap_reg;
  logic [31:0] opto_val_reg;
  logic [31:0] relay_val_reg;
  logic [31:0] alarm_pend_reg;
  logic fault_pend_reg;
  logic maint_pend_reg;
  logic opto_pend_reg;
  logic relay_pend_reg;
  logic [31:0] rd_mux;

  // register strobes
  wire wr_ctrl = wr_in && addr_in == EFRL_OFS_CTRL;
  wire wr_rtc_lo = wr_in && addr_in == EFRL_OFS_RTC_LO;
  wire wr_rtc_hi = wr_in && addr_in == EFRL_OFS_RTC_HI;
  wire ind_reset = wr_ctrl && wdata_in[EFRL_CTRL_IND_RST_BIT];
  wire [31:0] opto_mask = width_mask(ctrl_reg[EFRL_CTRL_OPTO_LSB +: 2]);
  wire [31:0] relay_mask = width_mask(ctrl_reg[EFRL_CTRL_RELAY_LSB +: 2]);
  wire ms_tick = ms_cnt_reg == MS_LAST;

  // change detection against the previous run; the first run after reset only primes
  wire run = prot_tick_in && primed_reg;
  wire opto_chg = run && (((opto_in ^ opto_snap_reg) & opto_mask) != '0);
  wire relay_chg = run && (((relay_in ^ relay_snap_reg) & relay_mask) != '0);
  wire [31:0] alarm_chg = run ? (alarm_in ^ alarm_snap_reg) : '0;

  // one event per cycle: records first, then inputs, contacts, lowest alarm bit
  wire any_alarm = alarm_pend_reg != '0;
  wire serve_fault = fault_pend_reg;
  wire serve_maint = maint_pend_reg && !fault_pend_reg;
  wire hi_busy = fault_pend_reg || maint_pend_reg;
  wire serve_opto = opto_pend_reg && !hi_busy;
  wire serve_relay = relay_pend_reg && !hi_busy && !opto_pend_reg;
  wire serve_alarm = any_alarm && !hi_busy && !opto_pend_reg && !relay_pend_reg;
  wire [4:0] alarm_pos = lowest_bit(alarm_pend_reg);
  wire [31:0] alarm_done = serve_alarm ? (32'h00000001 << alarm_pos) : '0;
  wire [31:0] alarm_word = {23'h000000, alarm_snap_reg[alarm_pos], 3'h0, alarm_pos};

  efrl_ev_t cur_type;
  logic [31:0] cur_val;
  always_comb begin
    cur_type = EFRL_EV_NONE;
    cur_val = '0;
    if (serve_fault) begin
      cur_type = EFRL_EV_FAULT;
    end else if (serve_maint) begin
      cur_type = EFRL_EV_MAINT;
    end else if (serve_opto) begin
      cur_type = EFRL_EV_OPTO;
      cur_val = opto_val_reg;
    end else if (serve_relay) begin
      cur_type = EFRL_EV_RELAY;
      cur_val = relay_val_reg;
    end else if (serve_alarm) begin
      cur_type = EFRL_EV_ALARM;
      cur_val = alarm_word;
    end
  end

  // store writes: every entry carries its millisecond time tag
  assign evt.wr_en = cur_type != EFRL_EV_NONE;
  assign evt.wr_data = {cur_type, cur_val, rtc_reg};
  assign flt.wr_en = fault_trig_in;
  assign flt.wr_data = {fault_data_in, rtc_reg};
  assign mnt.wr_en = maint_trig_in;
  assign mnt.wr_data = {maint_data_in, rtc_reg};
  assign evt.rd_idx = evt_sel_reg;
  assign flt.rd_idx = flt_sel_reg;
  assign mnt.rd_idx = mnt_sel_reg;

  // selected event fields, group is one for input and contact banks
  wire [EFRL_TYPE_W-1:0] sel_type = evt.rd_data[EFRL_EVT_DW-1 -: EFRL_TYPE_W];
  wire [31:0] sel_val = evt.rd_data[EFRL_TIME_W +: EFRL_VAL_W];
  wire [EFRL_TIME_W-1:0] sel_time = evt.rd_data[EFRL_TIME_W-1:0];
  wire sel_io = sel_type == EFRL_EV_OPTO || sel_type == EFRL_EV_RELAY;
  wire [3:0] sel_group = sel_io ? EFRL_GROUP_NUM : 4'h0;
  wire [127:0] sel_text = ev_text(efrl_ev_t'(sel_type), sel_val[EFRL_ALARM_STATE_BIT]);
  wire [31:0] evt_info = {24'h000000, sel_group, sel_type, evt.rd_valid};
  wire [EFRL_TIME_W-1:0] flt_time = flt.rd_data[EFRL_TIME_W-1:0];
  wire [EFRL_TIME_W-1:0] mnt_time = mnt.rd_data[EFRL_TIME_W-1:0];

  // lamps latch on trip; reset clears only elements no longer active
  assign led_next = (led_reg & ~(ind_reset ? ~elem_active_in : '0)) | trip_in;
  assign trip_led_out = led_reg;

  // read decode; unmapped offsets read as zero
  always_comb begin
    unique case (addr_in)
      EFRL_OFS_CTRL: rd_mux = {28'h0000000, ctrl_reg};
      EFRL_OFS_EVT_SEL: rd_mux = 32'(evt_sel_reg);
      EFRL_OFS_FLT_SEL: rd_mux = 32'(flt_sel_reg);
      EFRL_OFS_MNT_SEL: rd_mux = 32'(mnt_sel_reg);
      EFRL_OFS_EVT_INFO: rd_mux = evt_info;
      EFRL_OFS_EVT_TLO: rd_mux = sel_time[31:0];
      EFRL_OFS_EVT_THI: rd_mux = 32'(sel_time[EFRL_TIME_W-1:32]);
      EFRL_OFS_EVT_VAL: rd_mux = sel_val;
      EFRL_OFS_EVT_TXT0: rd_mux = sel_text[127:96];
      EFRL_OFS_EVT_TXT1: rd_mux = sel_text[95:64];
      EFRL_OFS_EVT_TXT2: rd_mux = sel_text[63:32];
      EFRL_OFS_EVT_TXT3: rd_mux = sel_text[31:0];
      EFRL_OFS_FLT_INFO: rd_mux = {31'h00000000, flt.rd_valid};
      EFRL_OFS_FLT_TLO: rd_mux = flt_time[31:0];
      EFRL_OFS_FLT_THI: rd_mux = 32'(flt_time[EFRL_TIME_W-1:32]);
      EFRL_OFS_FLT_DATA: rd_mux = flt.rd_data[EFRL_TIME_W +: EFRL_VAL_W];
      EFRL_OFS_MNT_INFO: rd_mux = {31'h00000000, mnt.rd_valid};
      EFRL_OFS_MNT_TLO: rd_mux = mnt_time[31:0];
      EFRL_OFS_MNT_THI: rd_mux = 32'(mnt_time[EFRL_TIME_W-1:32]);
      EFRL_OFS_MNT_DATA: rd_mux = mnt.rd_data[EFRL_TIME_W +: EFRL_VAL_W];
      EFRL_OFS_RTC_LO: rd_mux = rtc_reg[31:0];
      EFRL_OFS_RTC_HI: rd_mux = 32'(rtc_reg[EFRL_TIME_W-1:32]);
      EFRL_OFS_LED: rd_mux = 32'(led_reg);
      default: rd_mux = '0;
    endcase
  end

  // software registers and read data, valid only in the cycle after the strobe
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg <= EFRL_CTRL_RST;
      evt_sel_reg <= '0;
      flt_sel_reg <= '0;
      mnt_sel_reg <= '0;
      rtc_stage_reg <= '0;
      rdata_out <= '0;
    end else begin
      if (wr_ctrl) ctrl_reg <= wdata_in[3:0];
      if (wr_in && addr_in == EFRL_OFS_EVT_SEL) evt_sel_reg <= wdata_in[EFRL_EVT_IW-1:0];
      if (wr_in && addr_in == EFRL_OFS_FLT_SEL) flt_sel_reg <= wdata_in[EFRL_REC_IW-1:0];
      if (wr_in && addr_in == EFRL_OFS_MNT_SEL) mnt_sel_reg <= wdata_in[EFRL_REC_IW-1:0];
      if (wr_rtc_hi) rtc_stage_reg <= wdata_in[EFRL_RTC_HI_W-1:0];
      rdata_out <= rd_in ? rd_mux : '0;
    end
  end

  // millisecond divider and clock; a low-word write loads the staged high word
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ms_cnt_reg <= '0;
      rtc_reg <= '0;
    end else begin
      ms_cnt_reg <= (ms_tick || wr_rtc_lo) ? '0 : ms_cnt_reg + 1'b1;
      if (wr_rtc_lo) rtc_reg <= {rtc_stage_reg, wdata_in};
      else if (ms_tick) rtc_reg <= rtc_reg + 1'b1;
    end
  end

  // snapshots refresh on every run, pending flags let a new event win over service
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      primed_reg <= 1'b0;
      opto_snap_reg <= '0;
      relay_snap_reg <= '0;
      alarm_snap_reg <= '0;
      opto_val_reg <= '0;
      relay_val_reg <= '0;
      alarm_pend_reg <= '0;
      fault_pend_reg <= 1'b0;
      maint_pend_reg <= 1'b0;
      opto_pend_reg <= 1'b0;
      relay_pend_reg <= 1'b0;
      led_reg <= '0;
    end else begin
      if (prot_tick_in) begin
        primed_reg <= 1'b1;
        opto_snap_reg <= opto_in;
        relay_snap_reg <= relay_in;
        alarm_snap_reg <= alarm_in;
      end
      if (opto_chg) opto_val_reg <= opto_in & opto_mask;
      if (relay_chg) relay_val_reg <= relay_in & relay_mask;
      alarm_pend_reg <= (alarm_pend_reg & ~alarm_done) | alarm_chg;
      fault_pend_reg <= (fault_pend_reg && !serve_fault) || fault_trig_in;
      maint_pend_reg <= (maint_pend_reg && !serve_maint) || maint_trig_in;
      opto_pend_reg <= (opto_pend_reg && !serve_opto) || opto_chg;
      relay_pend_reg <= (relay_pend_reg && !serve_relay) || relay_chg;
      led_reg <= led_next;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in || store_rst_in);

  sequence s_opto_logged;
    ##[1:40] (evt.wr_en && cur_type == EFRL_EV_OPTO);
  endsequence
  sequence s_relay_logged;
    ##[1:40] (evt.wr_en && cur_type == EFRL_EV_RELAY);
  endsequence

  property p_opto_event;
    opto_chg |-> s_opto_logged;
  endproperty
  a_opto_event: assert property (p_opto_event) else $error("input change not logged");

  property p_relay_event;
    relay_chg |-> s_relay_logged;
  endproperty
  a_relay_event: assert property (p_relay_event) else $error("contact change not logged");

  property p_fault_event;
    fault_trig_in |-> ##[1:2] (evt.wr_en && cur_type == EFRL_EV_FAULT);
  endproperty
  a_fault_event: assert property (p_fault_event) else $error("fault record not logged");

  property p_rtc_step;
    ms_tick && !wr_rtc_lo |=> rtc_reg == $past(rtc_reg) + 1'b1 ##1 !ms_tick [*8];
  endproperty
  a_rtc_step: assert property (p_rtc_step) else $error("millisecond clock misstep");

  property p_snapshot;
    prot_tick_in |=> opto_snap_reg == $past(opto_in) && relay_snap_reg == $past(relay_in);
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("snapshot not refreshed");

  // checked at capture, so a later width change cannot trip it
  property p_opto_width;
    opto_chg |=> (opto_val_reg & ~$past(opto_mask)) == '0;
  endproperty
  a_opto_width: assert property (p_opto_width) else $error("input word exceeds width");

  // logged bit was pending and no lower pending bit was skipped
  property p_alarm_word;
    evt.wr_en && cur_type == EFRL_EV_ALARM |-> cur_val[31:9] == '0 && cur_val[7:5] == '0
      && alarm_pend_reg[cur_val[4:0]]
      && (alarm_pend_reg & ~({32{1'b1}} << cur_val[4:0])) == '0;
  endproperty
  a_alarm_word: assert property (p_alarm_word) else $error("alarm value malformed");

  property p_led_clear;
    ind_reset && trip_in == '0 |=> (led_reg & ~$past(elem_active_in)) == '0;
  endproperty
  a_led_clear: assert property (p_led_clear) else $error("reset lamp still lit");

  property p_group_one;
    evt.rd_valid && sel_io |-> evt_info[EFRL_INFO_GRP_LSB +: 4] == EFRL_GROUP_NUM;
  endproperty
  a_group_one: assert property (p_group_one) else $error("group number not one");
endmodule : efrl_top

// ---- shared/efrl_pkg.sv ----
// efrl_pkg: constants, register map and types of the event/fault record logger.
// assumes a single 40 MHz system clock and the plain strobe register port.
package efrl_pkg;
  // clock and real-time clock timing
  localparam int EFRL_CLK_PERIOD_NS = 25;
  localparam int EFRL_MS_NS = 1000000;
  localparam int EFRL_MS_CYCLES = EFRL_MS_NS / EFRL_CLK_PERIOD_NS;
  localparam int EFRL_MS_CNT_W = 16;
  localparam int EFRL_TIME_W = 48;
  localparam int EFRL_RTC_HI_W = 16;

  // stores
  localparam int EFRL_EVT_DEPTH = 512;
  localparam int EFRL_EVT_IW = 9;
  localparam int EFRL_REC_DEPTH = 10;
  localparam int EFRL_REC_IW = 4;
  localparam int EFRL_VAL_W = 32;
  localparam int EFRL_TYPE_W = 3;
  localparam int EFRL_EVT_DW = EFRL_TYPE_W + EFRL_VAL_W + EFRL_TIME_W;
  localparam int EFRL_REC_DW = EFRL_VAL_W + EFRL_TIME_W;
  localparam int EFRL_IO_W = 32;
  localparam int EFRL_LED_W = 8;
  localparam int EFRL_TEXT_W = 128;

  typedef enum logic [EFRL_TYPE_W-1:0] {
    EFRL_EV_NONE, EFRL_EV_OPTO, EFRL_EV_RELAY, EFRL_EV_ALARM, EFRL_EV_FAULT, EFRL_EV_MAINT
  } efrl_ev_t;

  // register byte offsets
  localparam logic [7:0] EFRL_OFS_CTRL = 8'h00;
  localparam logic [7:0] EFRL_OFS_EVT_SEL = 8'h04;
  localparam logic [7:0] EFRL_OFS_FLT_SEL = 8'h08;
  localparam logic [7:0] EFRL_OFS_MNT_SEL = 8'h0c;
  localparam logic [7:0] EFRL_OFS_EVT_INFO = 8'h10;
  localparam logic [7:0] EFRL_OFS_EVT_TLO = 8'h14;
  localparam logic [7:0] EFRL_OFS_EVT_THI = 8'h18;
  localparam logic [7:0] EFRL_OFS_EVT_VAL = 8'h1c;
  localparam logic [7:0] EFRL_OFS_EVT_TXT0 = 8'h20;
  localparam logic [7:0] EFRL_OFS_EVT_TXT1 = 8'h24;
  localparam logic [7:0] EFRL_OFS_EVT_TXT2 = 8'h28;
  localparam logic [7:0] EFRL_OFS_EVT_TXT3 = 8'h2c;
  localparam logic [7:0] EFRL_OFS_FLT_INFO = 8'h30;
  localparam logic [7:0] EFRL_OFS_FLT_TLO = 8'h34;
  localparam logic [7:0] EFRL_OFS_FLT_THI = 8'h38;
  localparam logic [7:0] EFRL_OFS_FLT_DATA = 8'h3c;
  localparam logic [7:0] EFRL_OFS_MNT_INFO = 8'h40;
  localparam logic [7:0] EFRL_OFS_MNT_TLO = 8'h44;
  localparam logic [7:0] EFRL_OFS_MNT_THI = 8'h48;
  localparam logic [7:0] EFRL_OFS_MNT_DATA = 8'h4c;
  localparam logic [7:0] EFRL_OFS_RTC_LO = 8'h50;
  localparam logic [7:0] EFRL_OFS_RTC_HI = 8'h54;
  localparam logic [7:0] EFRL_OFS_LED = 8'h58;

  // field positions and reset values
  localparam int EFRL_CTRL_OPTO_LSB = 0;
  localparam int EFRL_CTRL_RELAY_LSB = 2;
  localparam int EFRL_CTRL_IND_RST_BIT = 8;
  localparam logic [3:0] EFRL_CTRL_RST = 4'hf;
  localparam int EFRL_INFO_TYPE_LSB = 1;
  localparam int EFRL_INFO_GRP_LSB = 4;
  localparam logic [3:0] EFRL_GROUP_NUM = 4'h1;
  localparam int EFRL_ALARM_STATE_BIT = 8;

  // event word widths selected by a two-bit code
  localparam logic [31:0] EFRL_MASK12 = 32'h00000fff;
  localparam logic [31:0] EFRL_MASK16 = 32'h0000ffff;
  localparam logic [31:0] EFRL_MASK24 = 32'h00ffffff;
  localparam logic [31:0] EFRL_MASK32 = 32'hffffffff;

  // sixteen-character descriptions, first character in the top byte
  localparam logic [127:0] EFRL_TXT_OPTO = "LOGIC INPUTS 1  ";
  localparam logic [127:0] EFRL_TXT_RELAY = "OUTPUT CONTACTS1";
  localparam logic [127:0] EFRL_TXT_ALM_ON = "ALARM ON        ";
  localparam logic [127:0] EFRL_TXT_ALM_OFF = "ALARM OFF       ";
  localparam logic [127:0] EFRL_TXT_FAULT = "FAULT RECORDED  ";
  localparam logic [127:0] EFRL_TXT_MAINT = "MAINT RECORDED  ";
endpackage : efrl_pkg

// ---- shared/efrl_store_if.sv ----
// efrl_store_if: write and indexed-read signals between the logger and one record store.
// assumes the store answers a read index combinationally.
`timescale 1ns/1ps
interface efrl_store_if #(
  parameter int IW = 9,
  parameter int DW = 83
);
  logic wr_en;
  logic [DW-1:0] wr_data;
  logic [IW-1:0] rd_idx;
  logic rd_valid;
  logic [DW-1:0] rd_data;
  logic [IW:0] count;

  modport owner(output wr_en, wr_data, rd_idx, input rd_valid, rd_data, count);
  modport store(input wr_en, wr_data, rd_idx, output rd_valid, rd_data, count);
endinterface : efrl_store_if

// ---- verilog/efrl_ring.sv ----
// efrl_ring: circular record store, newest-first indexed read.
// assumes store_rst_in comes from the battery supply, not from main power.
`timescale 1ns/1ps
module efrl_ring #(
  parameter int DEPTH = 512,
  parameter int IW = 9,
  parameter int DW = 83
) (
  input wire logic clk_in,
  input wire logic store_rst_in,
  efrl_store_if.store st
);
  import efrl_pkg::*;

  localparam logic [IW-1:0] LAST = IW'(DEPTH - 1);
  localparam logic [IW:0] FULL = (IW + 1)'(DEPTH);
  localparam logic [IW:0] DEPTH_M1 = (IW + 1)'(DEPTH - 1);

  // array is never reset so its content outlives a main reset
  logic [DW-1:0] mem [DEPTH];
  logic [IW-1:0] head_reg;
  logic [IW-1:0] head_next;
  logic [IW:0] count_reg;
  logic [IW:0] count_next;

  // head wraps over the oldest entry once the store is full
  assign head_next = (head_reg == LAST) ? '0 : head_reg + 1'b1;
  assign count_next = (count_reg == FULL) ? count_reg : count_reg + 1'b1;

  // newest-first: index 0 is the slot just behind the head
  wire in_range = {1'b0, st.rd_idx} < count_reg;
  wire [IW:0] back_raw = {1'b0, head_reg} + DEPTH_M1 - {1'b0, st.rd_idx};
  wire [IW:0] back = (back_raw >= FULL) ? back_raw - FULL : back_raw;
  assign st.rd_valid = in_range;
  assign st.rd_data = in_range ? mem[back[IW-1:0]] : '0; // empty beyond fill
  assign st.count = count_reg;

  // pointers follow the battery reset only
  always_ff @(posedge clk_in or posedge store_rst_in) begin
    if (store_rst_in) begin
      head_reg <= '0;
      count_reg <= '0;
    end else if (st.wr_en) begin
      head_reg <= head_next;
      count_reg <= count_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (st.wr_en) begin
      mem[head_reg] <= st.wr_data;
    end
  end

  property p_count_step;
    @(posedge clk_in) disable iff (store_rst_in)
    st.wr_en && (count_reg < FULL) |=> count_reg == $past(count_reg) + 1'b1;
  endproperty
  a_count_step: assert property (p_count_step) else $error("store fill count did not step");

  property p_empty_read;
    @(posedge clk_in) disable iff (store_rst_in)
    ({1'b0, st.rd_idx} >= count_reg) |-> (!st.rd_valid && st.rd_data == '0);
  endproperty
  a_empty_read: assert property (p_empty_read) else $error("unfilled index gave data");
endmodule : efrl_ring

// ---- testbench/efrl_reader.sv ----
// efrl_reader: record reader on the far side, display or remote port.
// assumes the plain strobe port; read data stand one cycle after rd.
`timescale 1ns/1ps
module efrl_reader (
  input wire logic clk_in,
  input wire logic [31:0] rdata_in,
  output logic [7:0] addr_out,
  output logic [31:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  initial begin
    addr_out = 8'h00;
    wdata_out = 32'h00000000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // one-cycle write strobe beside address and data
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
  endtask : wr
  // data taken in the one cycle it stands
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1 d = rdata_in;
  endtask : rd
endmodule : efrl_reader

// ---- testbench/efrl_top_bench.sv ----
// efrl_top_bench: self-checking bench of the record logger.
// assumes a shortened millisecond divider of 20 cycles.
`timescale 1ns/1ps
module efrl_top_bench;
  import efrl_pkg::*;
  logic clk = 1'b0, rst = 1'b1, srst = 1'b1, tick = 1'b0, ftrig = 1'b0, mtrig = 1'b0;
  logic [31:0] opto = '0, relay = '0, alarm = '0, fdata = 32'h0000abcd, mdata = '0, rdata, d;
  logic [7:0] trip = '0, act = '0, leds, addr;
  logic [31:0] wdata;
  logic wr, rd;
  int mismatches = 0, num_checks = 0;
  efrl_top #(.MS_CYCLES(20)) dut_u (.clk_in(clk), .rst_in(rst), .store_rst_in(srst),
    .prot_tick_in(tick), .opto_in(opto), .relay_in(relay), .alarm_in(alarm),
    .fault_trig_in(ftrig), .fault_data_in(fdata), .maint_trig_in(mtrig),
    .maint_data_in(mdata), .trip_in(trip), .elem_active_in(act), .trip_led_out(leds),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata));
  efrl_reader rdr_u (.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd));
  // 25 ns clock
  always #12.5 clk = ~clk;
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (e !== g) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    rdr_u.rd(a, d);
    chk(n, e, d);
  endtask : rchk
  // ticks spaced well past the worst service time
  task run_tick;
    @(posedge clk) tick <= 1'b1;
    @(posedge clk) tick <= 1'b0;
    repeat (40) @(posedge clk);
  endtask : run_tick
  task summarize;
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  // reset state, empty event store, width codes, first tick only primes
  task t_reset;
    rchk("ctrl", EFRL_OFS_CTRL, 32'h0000000f);
    rchk("empty", EFRL_OFS_EVT_INFO, 32'h00000000);
    rdr_u.wr(EFRL_OFS_CTRL, 32'h00000008);
    run_tick();
    rchk("primed", EFRL_OFS_EVT_INFO, 32'h00000000);
  endtask : t_reset
  // opto and contact change in one run, masked, newest first
  task t_io;
    @(posedge clk) opto <= 32'hfff5a5a5;
    relay <= 32'h77654321;
    run_tick();
    rchk("rly", EFRL_OFS_EVT_INFO, 32'h00000015);
    rchk("rlyv", EFRL_OFS_EVT_VAL, 32'h00654321);
    rdr_u.wr(EFRL_OFS_EVT_SEL, 32'h00000001);
    rchk("opt", EFRL_OFS_EVT_INFO, 32'h00000013);
    rchk("optv", EFRL_OFS_EVT_VAL, 32'h000005a5);
    rchk("txt", EFRL_OFS_EVT_TXT0, "LOGI");
    rdr_u.wr(EFRL_OFS_EVT_SEL, 32'h00000002);
    rchk("old", EFRL_OFS_EVT_INFO, 32'h00000000);
    run_tick();
    rdr_u.wr(EFRL_OFS_EVT_SEL, 32'h00000000);
    rchk("still", EFRL_OFS_EVT_INFO, 32'h00000015);
  endtask : t_io
  // alarm, fault record and real-time clock
  task t_rec;
    @(posedge clk) alarm <= 32'h00000008;
    run_tick();
    rchk("alm", EFRL_OFS_EVT_VAL, 32'h00000103);
    rchk("almtxt", EFRL_OFS_EVT_TXT1, "M ON");
    @(posedge clk) ftrig <= 1'b1;
    @(posedge clk) ftrig <= 1'b0;
    repeat (10) @(posedge clk);
    rchk("fev", EFRL_OFS_EVT_INFO, 32'h00000009);
    rchk("fvld", EFRL_OFS_FLT_INFO, 32'h00000001);
    rchk("fdat", EFRL_OFS_FLT_DATA, 32'h0000abcd);
    rdr_u.wr(EFRL_OFS_FLT_SEL, 32'h00000001);
    rchk("fold", EFRL_OFS_FLT_INFO, 32'h00000000);
    rdr_u.wr(EFRL_OFS_RTC_HI, 32'h00000001);
    rdr_u.wr(EFRL_OFS_RTC_LO, 32'h00000064);
    repeat (99) @(posedge clk);
    rdr_u.rd(EFRL_OFS_RTC_LO, d);
    // five 20-cycle ticks since the load; the report below falls before the sixth
    chk("rtc", 32'h00000069, d);
    @(posedge clk) mtrig <= 1'b1;
    mdata <= 32'h00000042;
    @(posedge clk) mtrig <= 1'b0;
    rchk("mvld", EFRL_OFS_MNT_INFO, 32'h00000001);
    rchk("mdat", EFRL_OFS_MNT_DATA, 32'h00000042);
    rchk("mtim", EFRL_OFS_MNT_TLO, 32'h00000069);
    rchk("mev", EFRL_OFS_EVT_INFO, 32'h0000000b);
    rchk("mevt", EFRL_OFS_EVT_TLO, 32'h00000069);
    rchk("mevh", EFRL_OFS_EVT_THI, 32'h00000001);
  endtask : t_rec
  // lamp clears only where the element has dropped out
  task t_lamp;
    @(posedge clk) trip <= 8'h03;
    @(posedge clk) trip <= 8'h00;
    act <= 8'h02;
    rchk("ledset", EFRL_OFS_LED, 32'h00000003);
    rdr_u.wr(EFRL_OFS_CTRL, 32'h00000108);
    rchk("led", EFRL_OFS_LED, 32'h00000002);
    chk("ledpin", 32'h2, {24'h0, leds});
  endtask : t_lamp
  // a main reset alone clears lamps and settings but keeps the stored records
  task t_keep;
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk("ledrst", 32'h0, {24'h0, leds});
    rchk("kept", EFRL_OFS_EVT_INFO, 32'h0000000b);
    rchk("ctrlrst", EFRL_OFS_CTRL, 32'h0000000f);
  endtask : t_keep
  // main sequence: two-cycle reset, then scenarios
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    srst <= 1'b0;
    t_reset();
    t_io();
    t_rec();
    t_lamp();
    t_keep();
    summarize();
  end
  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule : efrl_top_bench
